// ===== inc/ssef_pkg.sv
// Package with register map, field positions, reset values and carrier types of the status flag block.
package ssef_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] SSEF_ADDR_STATUS = 8'h00;
    localparam logic [7:0] SSEF_ADDR_CTRL = 8'h04;
    localparam logic [7:0] SSEF_ADDR_HOLD = 8'h08;
    localparam int SSEF_ADDR_W = 8;

    // ------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------
    localparam int SSEF_ST_TX_EMPTY = 7;
    localparam int SSEF_ST_RX_FULL = 6;
    localparam int SSEF_ST_OVERRUN = 5;
    localparam int SSEF_ST_FRAME_ERR = 4;
    localparam int SSEF_ST_PARITY_ERR = 3;
    localparam int SSEF_ST_TX_END = 2;
    localparam int SSEF_ST_RX_MP = 1;
    localparam int SSEF_ST_TX_MP = 0;
    localparam logic [7:0] SSEF_STATUS_RESET = 8'h84;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int SSEF_CT_RX_ON = 0;
    localparam int SSEF_CT_TX_ON = 1;
    localparam int SSEF_CT_SYNC = 2;
    localparam int SSEF_CT_MP_FMT = 3;
    localparam int SSEF_CT_PAR_EN = 4;
    localparam int SSEF_CT_PAR_ODD = 5;
    localparam int SSEF_CT_TWO_STOP = 6;
    localparam int SSEF_CT_W = 7;
    localparam logic [SSEF_CT_W-1:0] SSEF_CTRL_RESET = 7'h00;

    // ------------------------------------------------------------
    // Buffering
    // ------------------------------------------------------------
    localparam int SSEF_FIFO_DEPTH = 32;

    // One received character as handed over by the receive shifter.
    typedef struct packed {
        logic [7:0] data;
        logic parity_bit;
        logic mp_bit;
        logic stop1;
        logic stop2;
    } ssef_frame_t;

    localparam int SSEF_FRAME_W = $bits(ssef_frame_t);

    // Decoded control register.
    typedef struct packed {
        logic two_stop;
        logic par_odd;
        logic par_en;
        logic mp_fmt;
        logic sync;
        logic tx_on;
        logic rx_on;
    } ssef_ctrl_t;

endpackage

// ===== hw/ssef_status.sv
// Serial status flag block: APB registers, receive error checking, transmit end and multiprocessor bits.

// ------------------------------------------------------------
// Synchronous FIFO with flip-flop storage
// ------------------------------------------------------------
module ssef_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Fill side
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    // Drain side
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    assign o_ready = (cnt_q != (AW+1)'(DEPTH));
    assign o_valid = (cnt_q != '0);
    assign o_data = mem_q[rd_q];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    always_comb begin
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wr_q] = i_data;
            wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
        end
        if (pop) begin
            rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            mem_q <= mem_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end
endmodule

// ------------------------------------------------------------
// Top level
// ------------------------------------------------------------
module ssef_status (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ssef_pkg::SSEF_ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Power state
    input wire logic i_standby,
    // Receive shifter side
    input wire logic i_rx_valid,
    input wire ssef_pkg::ssef_frame_t i_rx_frame,
    output logic o_rx_ready,
    output logic [7:0] o_rx_hold,
    output logic o_rx_full_set,
    // Upper status flags kept by neighbouring logic
    input wire logic i_tx_empty,
    input wire logic i_rx_full,
    input wire logic i_overrun,
    // Transmit side
    input wire logic i_tx_empty_clr,
    input wire logic i_xfer_tx_write,
    input wire logic i_tx_last_bit,
    input wire logic i_tx_active,
    output logic o_tx_mp_bit,
    output logic o_tx_halt
);
    import ssef_pkg::*;

    ssef_ctrl_t ctrl_q, ctrl_d;
    logic fer_q, fer_d, per_q, per_d, transmit_end_flag_q, transmit_end_flag_d, mpb_q, mpb_d, tx_multiproc_bit_q, tx_multiproc_bit_d;
    logic fer_seen_q, fer_seen_d, per_seen_q, per_seen_d;
    logic [7:0] hold_q, hold_d;
    logic full_set_q, full_set_d;
    logic [31:0] rdata_q, rdata_d;
    logic slverr_q, slverr_d;
    logic [7:0] status;
    logic setup, access, wr_status, wr_ctrl, rd_status, hit;
    logic f_valid, f_ready;
    ssef_frame_t f_frame;
    logic pop, async_chk, frame_bad, parity_bad;

    // ------------------------------------------------------------
    // Receive buffer
    // ------------------------------------------------------------
    ssef_fifo #(
        .WIDTH(SSEF_FRAME_W),
        .DEPTH(SSEF_FIFO_DEPTH)
    ) u_rx_fifo (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_valid(i_rx_valid),
        .o_ready(o_rx_ready),
        .i_data(i_rx_frame),
        .o_valid(f_valid),
        .i_ready(f_ready),
        .o_data(f_frame)
    );

    // Errors stall draining; receive disable touches no flag.
    assign f_ready = ctrl_q.rx_on && !fer_q && !per_q && !i_standby;
    assign pop = f_valid && f_ready;
    assign async_chk = !ctrl_q.sync;
    assign frame_bad = async_chk && !f_frame.stop1;
    assign parity_bad = async_chk && ctrl_q.par_en && ((^f_frame.data ^ f_frame.parity_bit) != ctrl_q.par_odd);

    assign o_tx_halt = ctrl_q.sync && (fer_q || per_q);
    assign o_tx_mp_bit = tx_multiproc_bit_q && !ctrl_q.sync && ctrl_q.mp_fmt && i_tx_active;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    assign setup = i_psel && !i_penable;
    assign access = i_psel && i_penable;
    assign hit = (i_paddr == SSEF_ADDR_STATUS) || (i_paddr == SSEF_ADDR_CTRL) || (i_paddr == SSEF_ADDR_HOLD);
    assign wr_status = access && i_pwrite && (i_paddr == SSEF_ADDR_STATUS);
    assign wr_ctrl = access && i_pwrite && (i_paddr == SSEF_ADDR_CTRL);
    assign rd_status = access && !i_pwrite && (i_paddr == SSEF_ADDR_STATUS);
    assign o_pready = 1'b1;
    assign o_prdata = rdata_q;
    assign o_pslverr = slverr_q && access;
    assign o_rx_hold = hold_q;
    assign o_rx_full_set = full_set_q;

    always_comb begin
        status = '0;
        status[SSEF_ST_TX_EMPTY] = i_tx_empty;
        status[SSEF_ST_RX_FULL] = i_rx_full;
        status[SSEF_ST_OVERRUN] = i_overrun;
        status[SSEF_ST_FRAME_ERR] = fer_q;
        status[SSEF_ST_PARITY_ERR] = per_q;
        status[SSEF_ST_TX_END] = transmit_end_flag_q;
        status[SSEF_ST_RX_MP] = mpb_q;
        status[SSEF_ST_TX_MP] = tx_multiproc_bit_q;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        ctrl_d = ctrl_q;
        fer_d = fer_q;
        per_d = per_q;
        transmit_end_flag_d = transmit_end_flag_q;
        mpb_d = mpb_q;
        tx_multiproc_bit_d = tx_multiproc_bit_q;
        hold_d = hold_q;
        full_set_d = 1'b0;
        rdata_d = rdata_q;
        slverr_d = slverr_q;
        fer_seen_d = fer_seen_q;
        per_seen_d = per_seen_q;
        // Read data is captured in the setup cycle and shown in the access cycle.
        if (setup) begin
            slverr_d = !hit;
            rdata_d = '0;
            if (!i_pwrite && i_paddr == SSEF_ADDR_STATUS) begin
                rdata_d[7:0] = status;
            end else if (!i_pwrite && i_paddr == SSEF_ADDR_CTRL) begin
                rdata_d[SSEF_CT_W-1:0] = ctrl_q;
            end else if (!i_pwrite && i_paddr == SSEF_ADDR_HOLD) begin
                rdata_d[7:0] = hold_q;
            end
        end
        if (wr_ctrl) begin
            ctrl_d = ssef_ctrl_t'(i_pwdata[SSEF_CT_W-1:0]);
        end
        // Zero after read clears an error flag; one and the end bit are ignored; SSEF_ST_TX_MP takes the written value.
        if (wr_status) begin
            tx_multiproc_bit_d = i_pwdata[SSEF_ST_TX_MP];
            if (!i_pwdata[SSEF_ST_FRAME_ERR] && fer_seen_q) begin
                fer_d = 1'b0;
            end
            if (!i_pwdata[SSEF_ST_PARITY_ERR] && per_seen_q) begin
                per_d = 1'b0;
            end
        end
        if (i_tx_empty_clr || i_xfer_tx_write) begin
            transmit_end_flag_d = 1'b0;
        end
        if ((i_tx_last_bit && i_tx_empty) || (wr_ctrl && ctrl_q.tx_on && !i_pwdata[SSEF_CT_TX_ON])) begin
            transmit_end_flag_d = 1'b1;
        end
        if (pop) begin
            hold_d = f_frame.data;
            // Error sets win over software clears.
            if (frame_bad) begin
                fer_d = 1'b1;
            end
            if (parity_bad) begin
                per_d = 1'b1;
            end
            // Full flag only for clean characters.
            full_set_d = !frame_bad && !parity_bad;
            if (async_chk && ctrl_q.mp_fmt) begin
                mpb_d = f_frame.mp_bit;
            end
        end
        fer_seen_d = fer_d && (fer_seen_q || (rd_status && rdata_q[SSEF_ST_FRAME_ERR] && fer_q));
        per_seen_d = per_d && (per_seen_q || (rd_status && rdata_q[SSEF_ST_PARITY_ERR] && per_q));
        if (i_standby) begin
            fer_d = 1'b0;
            per_d = 1'b0;
            transmit_end_flag_d = 1'b1;
            mpb_d = 1'b0;
            tx_multiproc_bit_d = 1'b0;
            fer_seen_d = 1'b0;
            per_seen_d = 1'b0;
            full_set_d = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_q <= SSEF_CTRL_RESET;
            fer_q <= SSEF_STATUS_RESET[SSEF_ST_FRAME_ERR];
            per_q <= SSEF_STATUS_RESET[SSEF_ST_PARITY_ERR];
            transmit_end_flag_q <= SSEF_STATUS_RESET[SSEF_ST_TX_END];
            mpb_q <= SSEF_STATUS_RESET[SSEF_ST_RX_MP];
            tx_multiproc_bit_q <= SSEF_STATUS_RESET[SSEF_ST_TX_MP];
            fer_seen_q <= 1'b0;
            per_seen_q <= 1'b0;
            hold_q <= '0;
            full_set_q <= 1'b0;
            rdata_q <= '0;
            slverr_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            fer_q <= fer_d;
            per_q <= per_d;
            transmit_end_flag_q <= transmit_end_flag_d;
            mpb_q <= mpb_d;
            tx_multiproc_bit_q <= tx_multiproc_bit_d;
            fer_seen_q <= fer_seen_d;
            per_seen_q <= per_seen_d;
            hold_q <= hold_d;
            full_set_q <= full_set_d;
            rdata_q <= rdata_d;
            slverr_q <= slverr_d;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    property p_frame_set;
        pop && frame_bad && !i_standby |=> fer_q;
    endproperty
    a_frame_set: assert property (p_frame_set) else $error("frame error not set");

    property p_stop2_ignored;
        pop && async_chk && f_frame.stop1 && !f_frame.stop2 && !fer_q |=> !fer_q;
    endproperty
    a_stop2_ignored: assert property (p_stop2_ignored) else $error("second stop bit checked");

    property p_err_hold;
        pop && (frame_bad || parity_bad) && !i_standby |=> !o_rx_full_set && o_rx_hold == $past(f_frame.data);
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("error character mishandled");

    property p_halt;
        (fer_q || per_q) |-> !f_ready && (!ctrl_q.sync || o_tx_halt);
    endproperty
    a_halt: assert property (p_halt) else $error("operation not halted on error");

    property p_clear_needs_read;
        wr_status && !i_pwdata[SSEF_ST_FRAME_ERR] && fer_q && !fer_seen_q && !i_standby |=> fer_q;
    endproperty
    a_clear_needs_read: assert property (p_clear_needs_read) else $error("flag cleared without read");

    property p_clear_after_read;
        rd_status && rdata_q[SSEF_ST_PARITY_ERR] ##[2:3] wr_status && !i_pwdata[SSEF_ST_PARITY_ERR] && !pop
            |=> !per_q;
    endproperty
    a_clear_after_read: assert property (p_clear_after_read) else $error("flag not cleared");

    property p_rx_off_keeps;
        $fell(ctrl_q.rx_on) && !$past(pop) && !$past(i_standby) |-> $stable({fer_q, per_q, mpb_q});
    endproperty
    a_rx_off_keeps: assert property (p_rx_off_keeps) else $error("receive disable changed flags");

    property p_parity_set;
        pop && parity_bad && !i_standby |=> per_q;
    endproperty
    a_parity_set: assert property (p_parity_set) else $error("parity error not set");

    property p_transmit_end_flag_set;
        i_tx_last_bit && i_tx_empty |=> transmit_end_flag_q;
    endproperty
    a_transmit_end_flag_set: assert property (p_transmit_end_flag_set) else $error("transmit end not set");

    property p_transmit_end_flag_clr;
        (i_tx_empty_clr || i_xfer_tx_write) && !i_tx_last_bit && !wr_ctrl && !i_standby |=> !transmit_end_flag_q;
    endproperty
    a_transmit_end_flag_clr: assert property (p_transmit_end_flag_clr) else $error("transmit end not cleared");

    property p_transmit_end_flag_ro;
        wr_status && !i_tx_empty_clr && !i_xfer_tx_write && !i_tx_last_bit && !i_standby && !wr_ctrl
            |=> $stable(transmit_end_flag_q);
    endproperty
    a_transmit_end_flag_ro: assert property (p_transmit_end_flag_ro) else $error("transmit end written");

    property p_mpb_capture;
        pop && !ctrl_q.sync && ctrl_q.mp_fmt && !i_standby |=> mpb_q == $past(f_frame.mp_bit);
    endproperty
    a_mpb_capture: assert property (p_mpb_capture) else $error("multiprocessor bit not captured");

    property p_tx_multiproc_bit_gate;
        (ctrl_q.sync || !ctrl_q.mp_fmt || !i_tx_active) |-> !o_tx_mp_bit;
    endproperty
    a_tx_multiproc_bit_gate: assert property (p_tx_multiproc_bit_gate) else $error("multiprocessor bit not ignored");

    property p_no_set_by_one;
        wr_status && !fer_q && !pop |=> !fer_q;
    endproperty
    a_no_set_by_one: assert property (p_no_set_by_one) else $error("write set a flag");

    c_frame_err: cover property (pop && frame_bad);
    c_clear_seq: cover property (rd_status && fer_q ##[2:3] wr_status ##1 !fer_q);
    c_fifo_full: cover property (!o_rx_ready);
    c_transmit_end_flag: cover property (i_tx_last_bit && i_tx_empty ##1 transmit_end_flag_q);
endmodule

// ===== tb/ssef_peer.sv
// Far-side receive shifter model that offers framed characters on a valid/ready stream.
module ssef_peer (
    // Clock
    input wire logic i_clk,
    // Stream towards the block
    input wire logic i_rx_ready,
    output logic o_rx_valid,
    output ssef_pkg::ssef_frame_t o_rx_frame
);
    timeunit 1ns;
    timeprecision 1ps;
    import ssef_pkg::*;

    initial begin
        o_rx_valid = 1'b0;
        o_rx_frame = '0;
    end

    // Offers one frame after gap + 1 clock edges and holds it until taken or for up to 40 cycles; ok stays low if it is refused.
    task automatic send(input ssef_frame_t f, input int gap, output logic ok);
        int n;
        ok = 1'b0;
        repeat (gap + 1) @(posedge i_clk);
        o_rx_valid <= 1'b1;
        o_rx_frame <= f;
        for (n = 0; n < 40; n++) begin
            @(posedge i_clk);
            if (i_rx_ready === 1'b1) begin
                ok = 1'b1;
                break;
            end
        end
        o_rx_valid <= 1'b0;
        // A released data bus does not keep showing the last frame.
        o_rx_frame <= ~f;
    endtask
endmodule

// ===== tb/ssef_status_test.sv
// Self-checking testbench for the serial status flag block.
module ssef_status_test;
    timeunit 1ns;
    timeprecision 1ps;
    import ssef_pkg::*;

    // ------------------------------------------------------------
    // Design and far side
    // ------------------------------------------------------------
    logic clk, rstn, psel, pen, pwr, prdy, perr, stby, rxv, rxr, fset;
    logic txe, rxfull, ovr, txe_clr, xwr, lastb, txact, txmp, halt, er, ok;
    logic [7:0] padr;
    logic [7:0] hold;
    logic [31:0] pwd;
    logic [31:0] prd;
    logic [31:0] rd;
    ssef_frame_t rxf;
    int error_cnt = 0;
    int total_checks = 0;
    int fcnt = 0;

    ssef_status dut_u (
        .i_clk(clk), .i_resetn(rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(padr),
        .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr), .i_standby(stby),
        .i_rx_valid(rxv), .i_rx_frame(rxf), .o_rx_ready(rxr), .o_rx_hold(hold), .o_rx_full_set(fset),
        .i_tx_empty(txe), .i_rx_full(rxfull), .i_overrun(ovr), .i_tx_empty_clr(txe_clr),
        .i_xfer_tx_write(xwr), .i_tx_last_bit(lastb), .i_tx_active(txact), .o_tx_mp_bit(txmp),
        .o_tx_halt(halt)
    );

    ssef_peer peer_u (.i_clk(clk), .i_rx_ready(rxr), .o_rx_valid(rxv), .o_rx_frame(rxf));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (fset === 1'b1) begin
            fcnt <= fcnt + 1;
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        padr <= a;
        pwd <= wd;
        @(posedge clk);
        pen <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clk);
            if (prdy === 1'b1) break;
        end
        if (n == 16) begin
            error_cnt++;
            wrap_up();
        end
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic wctl(input logic [6:0] v);
        apb(1'b1, SSEF_ADDR_CTRL, {25'h0, v});
    endtask

    task automatic wst(input logic [31:0] v);
        apb(1'b1, SSEF_ADDR_STATUS, v);
    endtask

    // Reads the status word; the upper three bits mirror the neighbouring flag inputs.
    task automatic st(input logic [4:0] lo);
        apb(1'b0, SSEF_ADDR_STATUS, 32'h0);
        chk("status", rd, {24'h0, txe, rxfull, ovr, lo});
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic snd(input logic [7:0] d, input logic p, input logic m, input logic s1, input logic s2);
        peer_u.send({d, p, m, s1, s2}, 0, ok);
        chk("taken", 32'(ok), 32'h1);
        settle();
    endtask

    task automatic pulse(input int k);
        @(posedge clk);
        txe_clr <= (k == 0);
        lastb <= (k == 1);
        xwr <= (k == 2);
        @(posedge clk);
        txe_clr <= 1'b0;
        lastb <= 1'b0;
        xwr <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        st(5'h04);
        apb(1'b0, SSEF_ADDR_CTRL, 32'h0);
        chk("ctrl", rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk("slverr", 32'(er), 32'h1);
        chk("unmapped", rd, 32'h0);
        wst(32'h0000_00FF);
        st(5'h05);
        wst(32'h0);
        st(5'h04);
        $display("test reset done");
    endtask

    task automatic t_frame();
        int c;
        c = fcnt;
        wctl(7'h51);
        snd(8'h35, 1'b0, 1'b0, 1'b1, 1'b0);
        chk("hold", {24'h0, hold}, 32'h35);
        st(5'h04);
        snd(8'h96, 1'b0, 1'b0, 1'b0, 1'b1);
        chk("hold", {24'h0, hold}, 32'h96);
        chk("full", 32'(fcnt - c), 32'h1);
        snd(8'h0F, 1'b0, 1'b0, 1'b1, 1'b1);
        chk("hold", {24'h0, hold}, 32'h96);
        wctl(7'h55);
        settle();
        chk("halt", 32'(halt), 32'h1);
        wst(32'h0);
        st(5'h14);
        wctl(7'h50);
        st(5'h14);
        chk("halt", 32'(halt), 32'h0);
        wst(32'h0);
        st(5'h04);
        wctl(7'h51);
        settle();
        chk("hold", {24'h0, hold}, 32'h0F);
        chk("full", 32'(fcnt - c), 32'h2);
        $display("test frame error done");
    endtask

    task automatic t_par();
        int c;
        c = fcnt;
        wctl(7'h39);
        snd(8'h01, 1'b1, 1'b1, 1'b1, 1'b1);
        st(5'h0E);
        chk("hold", {24'h0, hold}, 32'h01);
        snd(8'h07, 1'b0, 1'b0, 1'b1, 1'b1);
        chk("hold", {24'h0, hold}, 32'h01);
        wctl(7'h38);
        st(5'h0E);
        wst(32'h0);
        st(5'h06);
        wctl(7'h39);
        settle();
        chk("hold", {24'h0, hold}, 32'h07);
        chk("full", 32'(fcnt - c), 32'h1);
        st(5'h04);
        $display("test parity done");
    endtask

    task automatic t_transmit_end_flag();
        pulse(0);
        st(5'h00);
        pulse(1);
        st(5'h04);
        pulse(2);
        st(5'h00);
        txe <= 1'b0;
        pulse(1);
        st(5'h00);
        txe <= 1'b1;
        wctl(7'h02);
        wctl(7'h00);
        st(5'h04);
        wst(32'h1);
        pulse(2);
        stby <= 1'b1;
        repeat (3) @(posedge clk);
        stby <= 1'b0;
        st(5'h04);
        $display("test transmit end done");
    endtask

    task automatic t_tx_multiproc_bit();
        logic [7:0] cs [4];
        cs = '{8'h8A, 8'h0A, 8'h8E, 8'h82};
        wst(32'h1);
        for (int i = 0; i < 4; i++) begin
            wctl(cs[i][6:0]);
            txact <= cs[i][7];
            settle();
            chk("tx_mp", 32'(txmp), 32'(i == 0));
        end
        wctl(7'h0A);
        wst(32'h0);
        settle();
        chk("tx_mp", 32'(txmp), 32'h0);
        txact <= 1'b0;
        $display("test multiprocessor send done");
    endtask

    task automatic t_fifo();
        int c;
        int n;
        wctl(7'h00);
        c = fcnt;
        for (int i = 0; i < 32; i++) begin
            peer_u.send({i[7:0], 4'hF}, i % 2, ok);
            chk("fill", 32'(ok), 32'h1);
        end
        peer_u.send({8'hAA, 4'hF}, 0, ok);
        chk("refused", 32'(ok), 32'h0);
        chk("ready", 32'(rxr), 32'h0);
        wctl(7'h01);
        for (n = 0; n < 200 && fcnt - c < 32; n++) begin
            @(posedge clk);
        end
        settle();
        chk("drained", 32'(fcnt - c), 32'd32);
        chk("hold", {24'h0, hold}, 32'h1F);
        chk("ready", 32'(rxr), 32'h1);
        apb(1'b0, SSEF_ADDR_HOLD, 32'h0);
        chk("hold_reg", rd, 32'h1F);
        $display("test buffer done");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        {psel, pen, pwr, stby, rxfull, txe_clr, xwr, lastb, txact} = '0;
        padr = 8'h00;
        pwd = 32'h0;
        txe = 1'b1;
        ovr = 1'b1;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_frame();
        t_par();
        t_transmit_end_flag();
        t_tx_multiproc_bit();
        t_fifo();
        wrap_up();
    end
endmodule
